// ### hdl/i2c_byte_transfer_manager.sv
`timescale 1ns/1ns
// Operation
// RULE1: timing from prescaler, clock and data delays
// RULE2: loaded byte moves to shifter after ack
// RULE3: empty transmit register stretches clock low
// RULE4: master mode always uses byte counter
// RULE5: slave counter off until enable set
// RULE6: byte count taken from eight-bit field
// RULE7: software sets refill beyond 255 or ack
// RULE8: refill done sets flag, interrupt if enabled
// RULE9: clock held low while done flag set
// RULE10: non-zero count write clears done flag
// RULE11: software clears refill on final count
// RULE12: master counter drives nack, stop, restart
// RULE13: slave receiver counter controls acknowledge
// RULE14: counter places pec send and check
// RULE15: empty flag set on move, cleared on write
module i2c_byte_transfer_manager (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // timing register fields
    input  wire logic [3:0] timing_prescaler,
    input  wire logic [3:0] clock_line_delay,
    input  wire logic [3:0] data_line_delay,
    // second control register fields
    input  wire logic       master_mode,
    input  wire logic       slave_counter_enable,
    input  wire logic       refill_mode,
    input  wire logic       auto_end,
    input  wire logic       pec_enable,
    input  wire logic       count_done_irq_enable,
    input  wire logic [7:0] byte_count_field,
    input  wire logic       byte_count_write,
    // transmit data register write
    input  wire logic [7:0] tx_wdata,
    input  wire logic       tx_write,
    // bus events from the line engine
    input  wire logic       receiving,
    input  wire logic       scl_fall,
    input  wire logic       scl_rise,
    // pins
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    // status and byte-close requests
    output logic            transmit_empty_flag,
    output logic            count_done_flag,
    output logic            count_done_irq,
    output logic            counter_active,
    output logic [7:0]      bytes_left,
    output logic            ack_value,
    output logic            nack_request,
    output logic            stop_request,
    output logic            restart_request,
    output logic            pec_slot
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] transmit_data_register;
    logic [7:0] shift_register;
    logic [3:0] bit_pos;
    logic       byte_end;
    logic       stretch_tx;
    logic       hold_done;
    logic       sda_go;
    logic       setup_go;
    logic       sda_pend;

    // counter in use: always as master, in slave only when enabled
    assign counter_active = master_mode | slave_counter_enable; // RULE4 RULE5

    // ninth pulse (ack) has ended when falling edge follows bit index 8
    assign byte_end = scl_fall & (bit_pos == i2c_xfer_pkg::BITS_PER_BYTE);

    ////////////////////////////////////////////////////////////////////////
    // bit position within the 9-pulse byte frame
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_pos <= 4'h0;
        end else if (scl_fall && !stretch_tx && !hold_done) begin
            if (bit_pos == i2c_xfer_pkg::BITS_PER_BYTE) begin
                bit_pos <= 4'h0;
            end else begin
                bit_pos <= bit_pos + 4'h1;
            end
        end
    end

    // transmit data register and empty flag; write wins over move
    // when both coincide on a full register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_data_register <= i2c_xfer_pkg::TX_RESET;
            transmit_empty_flag    <= 1'b1;
        end else if (tx_write) begin
            transmit_data_register <= tx_wdata;
            transmit_empty_flag    <= 1'b0; // RULE15
        end else if (byte_end && !receiving && !transmit_empty_flag) begin
            transmit_empty_flag <= 1'b1; // RULE15
        end
    end

    // shifter load after ack pulse, then shift one bit per falling edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_register <= i2c_xfer_pkg::TX_RESET;
        end else if (byte_end && !receiving && !transmit_empty_flag) begin
            shift_register <= transmit_data_register; // RULE2
        end else if (sda_go && bit_pos != 4'h0 &&
                     bit_pos < i2c_xfer_pkg::BITS_PER_BYTE) begin
            shift_register <= {shift_register[6:0], 1'b0}; // RULE2
        end
    end

    // stretch when empty at byte end, until software writes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stretch_tx <= 1'b0;
        end else if (tx_write) begin
            stretch_tx <= 1'b0; // RULE3
        end else if (byte_end && !receiving && transmit_empty_flag) begin
            stretch_tx <= 1'b1; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte counter: load on field write, count down at each byte end while active, holding at zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bytes_left <= i2c_xfer_pkg::COUNT_RESET;
        end else if (byte_count_write) begin
            bytes_left <= byte_count_field; // RULE6
        end else if (byte_end && counter_active && bytes_left != 8'h00) begin
            bytes_left <= bytes_left - 8'h01;
        end
    end

    // done flag in refill mode; set wins over clearing write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_done_flag <= 1'b0;
        end else if (byte_end && counter_active && refill_mode &&
                     bytes_left == 8'h01) begin
            count_done_flag <= 1'b1; // RULE8
        end else if (byte_count_write && byte_count_field != 8'h00) begin
            count_done_flag <= 1'b0; // RULE10
        end
    end

    assign count_done_irq = count_done_flag & count_done_irq_enable; // RULE8
    assign hold_done      = count_done_flag; // RULE9

    // byte-close decisions at count one (nack) or once the count is spent (stop, restart), refill off
    assign nack_request    = master_mode & receiving & !refill_mode &
                             (bytes_left == 8'h01); // RULE12
    assign stop_request    = master_mode & !refill_mode & auto_end &
                             (bytes_left == 8'h00); // RULE12
    assign restart_request = master_mode & !refill_mode & !auto_end &
                             (bytes_left == 8'h00); // RULE12
    // slave ack: nack last byte unless refill lets software decide
    assign ack_value       = !(slave_counter_enable & !master_mode &
                               receiving & !refill_mode &
                               (bytes_left == 8'h01)); // RULE13
    assign pec_slot        = pec_enable & counter_active &
                             (bytes_left == 8'h01); // RULE14

    ////////////////////////////////////////////////////////////////////////
    // data-line delay after scl falls, clock-line delay for setup
    i2c_delay_timer u_data_delay (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .prescaler (timing_prescaler),
        .delay     (data_line_delay),
        .start     (scl_fall),
        .done      (sda_go)
    ); // RULE1

    i2c_delay_timer u_setup_delay (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .prescaler (timing_prescaler),
        .delay     (clock_line_delay),
        .start     (sda_go),
        .done      (setup_go)
    ); // RULE1

    // scl released only after setup elapsed since data change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sda_pend <= 1'b0;
        end else if (sda_go) begin
            sda_pend <= 1'b1; // RULE1
        end else if (setup_go || scl_rise) begin
            sda_pend <= 1'b0;
        end
    end

    // data pin driven low for zero bits and acks; released otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe <= 1'b0;
        end else if (sda_go) begin
            if (bit_pos == i2c_xfer_pkg::BITS_PER_BYTE) begin
                sda_oe <= receiving & ack_value;
            end else begin
                sda_oe <= !receiving & !shift_register[7];
            end
        end
    end

    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    // clock stretched for empty data, count done, or pending setup
    assign scl_oe  = stretch_tx | hold_done |
                     (sda_pend & !scl_in); // RULE3 RULE9
endmodule

// ### shared/i2c_xfer_pkg.sv
package i2c_xfer_pkg;
    // timing field layout inside the timing register word
    localparam int TIMING_WIDTH    = 12;
    localparam int SCALE_LSB       = 0;
    localparam int CLKDEL_LSB      = 4;
    localparam int DATDEL_LSB      = 8;
    localparam int FIELD_WIDTH     = 4;
    localparam logic [11:0] TIMING_RESET = 12'h000;
    // byte counter
    localparam int COUNT_WIDTH     = 8;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    // bits in a byte and ack slot index (ninth pulse)
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] TX_RESET = 8'h00;
endpackage

// ### hdl/i2c_delay_timer.sv
`timescale 1ns/1ns
module i2c_delay_timer (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // configuration
    input  wire logic [3:0] prescaler,
    input  wire logic [3:0] delay,
    // control
    input  wire logic       start,
    output logic            done
);
    logic [3:0] pre_cnt;
    logic [4:0] del_cnt;
    logic       busy;

    // prescaled countdown of (delay+1) ticks, done pulses one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 4'h0;
            del_cnt <= 5'h00;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                pre_cnt <= prescaler;
                del_cnt <= {1'b0, delay};
                busy    <= 1'b1;
            end else if (busy) begin
                if (pre_cnt != 4'h0) begin
                    pre_cnt <= pre_cnt - 4'h1;
                end else if (del_cnt != 5'h00) begin
                    pre_cnt <= prescaler;
                    del_cnt <= del_cnt - 5'h01;
                end else begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ### test/i2c_btm_properties.sv
`timescale 1ns/1ns
// port checks for the byte transfer manager
module i2c_btm_properties (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // controls
    input wire logic       master_mode,
    input wire logic       slave_counter_enable,
    input wire logic       count_done_irq_enable,
    input wire logic [7:0] byte_count_field,
    input wire logic       byte_count_write,
    input wire logic       tx_write,
    input wire logic       scl_fall,
    // status
    input wire logic       scl_oe,
    input wire logic       transmit_empty_flag,
    input wire logic       count_done_flag,
    input wire logic       count_done_irq,
    input wire logic       counter_active,
    input wire logic [7:0] bytes_left
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // a count write that releases the done flag
    wire clr = byte_count_write && (byte_count_field != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    chk_write_fills: assert property (tx_write
        |=> !transmit_empty_flag)
        else $error("empty flag still set after a data write");
    chk_empty_holds: assert property (transmit_empty_flag && !tx_write
        |=> transmit_empty_flag)
        else $error("empty flag cleared without a data write");
    chk_done_holds: assert property (count_done_flag && !clr
        |=> count_done_flag)
        else $error("done flag dropped without a nonzero count");
    chk_done_clears: assert property (count_done_flag && clr && !scl_fall
        |=> !count_done_flag)
        else $error("done flag kept after a nonzero count");
    chk_done_stretch: assert property (count_done_flag |-> scl_oe)
        else $error("clock not stretched while done");
    chk_irq_gate: assert property (1'b1 |->
        count_done_irq == (count_done_flag && count_done_irq_enable))
        else $error("done interrupt wrong");
    chk_master_counter: assert property (master_mode |-> counter_active)
        else $error("counter idle in master mode");
    chk_slave_counter: assert property (!master_mode |->
        counter_active == slave_counter_enable)
        else $error("slave counter enable not followed");
    chk_count_load: assert property (byte_count_write && !scl_fall
        |=> bytes_left == $past(byte_count_field))
        else $error("byte count not loaded");

    // main scenarios reached
    cover property (count_done_flag && scl_oe);
    cover property (transmit_empty_flag && scl_oe);
    cover property ($fell(count_done_flag));
endmodule

bind i2c_byte_transfer_manager i2c_btm_properties chk (.*);

// ### test/i2c_bus_peer.sv
`timescale 1ns/1ns
// bus peer that clocks scl and waits while the line is held low
module i2c_bus_peer (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // control and pins
    input  wire logic run,
    input  wire logic scl_oe,
    output logic      scl_in,
    output logic      scl_fall,
    output logic      scl_rise
);
    logic       peer_scl;
    logic       last;
    logic [1:0] div;
    // wired-and with a pull-up: a stretch keeps the line low
    assign scl_in   = peer_scl && !scl_oe;
    assign scl_fall = last && !scl_in;
    assign scl_rise = !last && scl_in;
    // half period of four cycles, paused while the line is held
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            peer_scl <= 1'b1;
            div      <= 2'd0;
            last     <= 1'b1;
        end else begin
            last <= scl_in;
            if (run && (scl_in == peer_scl)) begin
                div <= div + 2'd1;
                if (div == 2'd3) begin
                    peer_scl <= !peer_scl;
                end
            end
        end
    end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
// bench for the byte transfer manager
module tb_top;
    logic       mclk, rst_n, run, master_mode, slave_counter_enable;
    logic       refill_mode, count_done_irq_enable, byte_count_write;
    logic       tx_write, scl_in, scl_fall, scl_rise, scl_oe, sda_oe;
    logic       transmit_empty_flag, count_done_flag, count_done_irq;
    logic       counter_active, stop_request;
    logic [3:0] tim;
    logic [7:0] byte_count_field, tx_wdata, bytes_left;
    int         n_fail, num_checks, cycles;

    i2c_byte_transfer_manager uut (.mclk, .rst_n, .timing_prescaler(tim),
        .clock_line_delay(tim), .data_line_delay(tim), .master_mode,
        .slave_counter_enable, .refill_mode, .auto_end(1'b1),
        .pec_enable(1'b0), .count_done_irq_enable, .byte_count_field,
        .byte_count_write, .tx_wdata, .tx_write, .receiving(1'b0),
        .scl_fall, .scl_rise, .scl_in, .scl_out(), .scl_oe, .sda_out(),
        .sda_oe, .transmit_empty_flag, .count_done_flag, .count_done_irq,
        .counter_active, .bytes_left, .ack_value(), .nack_request(),
        .stop_request, .restart_request(), .pec_slot());
    i2c_bus_peer peer (.mclk, .rst_n, .run, .scl_oe, .scl_in, .scl_fall,
        .scl_rise);

    ////////////////////////////////////////////////////////////////////////
    // clock and hang limit
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one byte on the wire: nine falling edges
    task automatic byte_clk;
        int k;
        k = 0;
        run = 1'b1;
        while (k < 9) begin
            tick(1);
            if (scl_fall === 1'b1) k++;
        end
        run = 1'b0;
    endtask
    task automatic pulse_count(input logic [7:0] n);
        byte_count_field = n;
        byte_count_write = 1'b1;
        tick(1);
        byte_count_write = 1'b0;
        tick(1);
    endtask
    task automatic pulse_tx(input logic [7:0] d);
        tx_wdata = d;
        tx_write = 1'b1;
        tick(1);
        tx_write = 1'b0;
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({7'h0, transmit_empty_flag}, 8'h01);
        chk({7'h0, count_done_flag}, 8'h00);
        chk(bytes_left, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_counter;
        tick(1);
        chk({7'h0, counter_active}, 8'h00);
        slave_counter_enable = 1'b1;
        tick(1);
        chk({7'h0, counter_active}, 8'h01);
        slave_counter_enable = 1'b0;
        master_mode = 1'b1;
        tick(1);
        chk({7'h0, counter_active}, 8'h01);
        $display("test counter enable done");
    endtask
    task automatic t_refill;
        refill_mode = 1'b1;
        pulse_count(8'h01);
        chk(bytes_left, 8'h01);
        pulse_tx(8'ha5);
        chk({7'h0, transmit_empty_flag}, 8'h00);
        byte_clk();
        tick(2);
        chk({7'h0, transmit_empty_flag}, 8'h01);
        chk({7'h0, count_done_flag}, 8'h01);
        chk({7'h0, count_done_irq}, 8'h01);
        run = 1'b1;
        tick(12);
        chk({7'h0, scl_in}, 8'h00);
        run = 1'b0;
        count_done_irq_enable = 1'b0;
        tick(1);
        chk({7'h0, count_done_irq}, 8'h00);
        pulse_count(8'h00);
        chk({7'h0, count_done_flag}, 8'h01);
        refill_mode = 1'b0;
        pulse_count(8'h02);
        chk({7'h0, count_done_flag}, 8'h00);
        chk(bytes_left, 8'h02);
        $display("test refill done");
    endtask
    task automatic t_stretch;
        byte_clk();
        tick(2);
        chk({7'h0, scl_oe}, 8'h01);
        run = 1'b1;
        tick(10);
        chk({7'h0, scl_in}, 8'h00);
        pulse_tx(8'h3c);
        tick(1);
        chk({7'h0, scl_oe}, 8'h00);
        run = 1'b0;
        chk(bytes_left, 8'h01);
        chk({7'h0, stop_request}, 8'h00);
        pulse_count(8'h00);
        chk({7'h0, stop_request}, 8'h01);
        $display("test empty stretch done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // reset, then scenarios in order
    initial begin
        {rst_n, run, master_mode, slave_counter_enable, refill_mode} = 5'h0;
        {byte_count_write, tx_write, byte_count_field, tx_wdata} = 18'h0;
        count_done_irq_enable = 1'b1;
        tim = 4'h1;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_reset();
        t_counter();
        t_refill();
        t_stretch();
        wrap_up();
    end
endmodule
